// ==== hw/ecls_consts.svh ====
// offsets, field positions, reset values and frame timing of the lane serializer
`ifndef ECLS_CONSTS_SVH
`define ECLS_CONSTS_SVH
`define ECLS_OFF_CTRL       8'h00
`define ECLS_OFF_STATUS     8'h04
`define ECLS_OFF_SENT       8'h08
`define ECLS_OFF_DROPS      8'h0c
`define ECLS_CTRL_TX_EN     0
`define ECLS_CTRL_SCR_EN    1
`define ECLS_CTRL_RESET     2'h3
`define ECLS_LFSR_SEED      32'h1d2c3b4a
`define ECLS_DUAL_FRAME     5'h13
`define ECLS_QUAD_FRAME     5'h0b
`define ECLS_DUAL_HALF      5'h08
`define ECLS_QUAD_HALF      5'h04
`endif

// ==== hw/ecls_pkg.sv ====
// types shared by the lane serializer
package ecls_pkg;
    typedef struct packed {
        logic [31:0] word;
        logic        strobe;
        logic        rising;
        logic        quad;
        logic        bist;
        logic        pdn;
        logic        rsvd;
    } ecls_pins_s;
    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } ecls_state_e;
    typedef logic [18:0] ecls_frame_t;
endpackage

// ==== hw/ecls_serializer.sv ====
// embedded clock lane serializer with apb status and control
// What this block does
// - one 32-bit word per parallel strobe is sent over the chosen lanes
// - lane select low gives two lanes, high gives four
// - edge select high samples on rising strobe edge, low on falling
// - power-down low puts lanes in standby and stops the pll
// - self-test input low is normal operation, high is self-test
// - self-test drives the link back to back at full speed
// - payload is scrambled and dc-balanced before going out
// - each lane frame starts with a transition that carries timing
`timescale 1ns/100ps
`include "ecls_consts.svh"
module ecls_serializer
    import ecls_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // parallel side pins
    input  wire logic [31:0] parallel_word_in,
    input  wire logic        parallel_strobe_clock,
    // configuration pins
    input  wire logic        strobe_edge_select,
    input  wire logic        lane_count_select,
    input  wire logic        self_test_enable,
    input  wire logic        power_down_n,
    input  wire logic        reserved_cfg,
    // serial lanes
    output logic      [3:0]  serial_lane_out,
    output logic      [3:0]  serial_lane_oe,
    output logic             pll_running,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    ecls_pins_s  sync1;
    ecls_pins_s  sync2;
    logic        strobe_d;
    ecls_state_e state;
    logic [4:0]  bit_cnt;
    logic        quad_q;
    logic [31:0] lfsr;
    logic [31:0] test_word;
    logic [3:0]  lane_bit;
    logic [1:0]  ctrl;
    logic [15:0] words_sent;
    logic [15:0] words_dropped;

    // pins from outside the clock domain pass two flops before use
    always_ff @(posedge clk) begin
        sync1 <= '{word: parallel_word_in, strobe: parallel_strobe_clock,
                   rising: strobe_edge_select, quad: lane_count_select,
                   bist: self_test_enable, pdn: power_down_n, rsvd: reserved_cfg};
        sync2 <= sync1;
    end

    // power-down acts as a reset of the whole transmit path
    wire         core_rst  = sys_rst | ~sync2.pdn;
    wire         str_rise  = sync2.strobe & ~strobe_d;
    wire         str_fall  = ~sync2.strobe & strobe_d;
    wire         take      = sync2.rising ? str_rise : str_fall;
    wire         tx_en     = ctrl[`ECLS_CTRL_TX_EN];
    wire [4:0]   frame_len = quad_q ? `ECLS_QUAD_FRAME : `ECLS_DUAL_FRAME;
    wire         last_bit  = (state == ST_SHIFT) && (bit_cnt == frame_len - 5'h01);
    wire         can_load  = (state == ST_IDLE) || last_bit;
    // self-test does not wait for the strobe, so it keeps the lanes saturated
    wire         want      = tx_en & (sync2.bist | take);
    wire         load      = want & can_load;
    wire         drop      = tx_en & ~sync2.bist & take & ~can_load;
    wire [31:0]  src_word  = sync2.bist ? test_word : sync2.word;
    wire [31:0]  scr_word  = ctrl[`ECLS_CTRL_SCR_EN] ? (src_word ^ lfsr) : src_word;
    wire [31:0]  lfsr_next = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    wire         quad_sel  = sync2.quad;

    // start bit one, stop bit zero: every frame carries a rising transition
    function automatic ecls_frame_t build_frame(input logic [15:0] chunk,
                                                input logic        quad);
        logic [4:0]  ones;
        logic        inv;
        logic [15:0] pay;
        ones = 5'h00;
        for (int i = 0; i < 16; i++) begin
            ones = ones + {4'h0, chunk[i]};
        end
        inv = ones > (quad ? `ECLS_QUAD_HALF : `ECLS_DUAL_HALF);
        pay = inv ? ~chunk : chunk;
        if (quad) begin
            build_frame = {8'h00, 1'b0, inv, pay[7:0], 1'b1};
        end else begin
            build_frame = {1'b0, inv, pay, 1'b1};
        end
    endfunction

    // no reset here: a constant would fake an edge when the strobe idles high
    always_ff @(posedge clk) begin
        strobe_d <= sync2.strobe;
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            state   <= ST_IDLE;
            bit_cnt <= 5'h00;
            quad_q  <= 1'b0;
        end else if (load) begin
            state   <= ST_SHIFT;
            bit_cnt <= 5'h00;
            quad_q  <= quad_sel;
        end else begin
            case (state)
                ST_IDLE: begin
                    bit_cnt <= 5'h00;
                end
                ST_SHIFT: begin
                    if (last_bit) begin
                        state <= ST_IDLE;
                    end
                    bit_cnt <= bit_cnt + 5'h01;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            lfsr      <= `ECLS_LFSR_SEED;
            test_word <= 32'h00000000;
        end else if (load) begin
            lfsr      <= lfsr_next;
            test_word <= sync2.bist ? test_word + 32'h00000001 : test_word;
        end
    end

    genvar l;
    generate
        for (l = 0; l < 4; l++) begin : g_lane
            // dual mode carries 16 bits on lanes 0 and 1, lanes 2 and 3 get nothing
            wire [15:0] chunk = quad_sel ? {8'h00, scr_word[8*l +: 8]} :
                                (l < 2) ? scr_word[16*(l%2) +: 16] : 16'h0000;
            wire        used  = quad_sel || (l < 2);
            ecls_frame_t shift_q;
            always_ff @(posedge clk) begin
                if (core_rst) begin
                    shift_q <= '0;
                end else if (load) begin
                    shift_q <= used ? build_frame(chunk, quad_sel) : '0;
                end else if (state == ST_SHIFT) begin
                    shift_q <= {1'b0, shift_q[18:1]};
                end
            end
            assign lane_bit[l] = shift_q[0];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (core_rst) begin
            serial_lane_out <= 4'h0;
            serial_lane_oe  <= 4'h0;
        end else begin
            serial_lane_out <= lane_bit & {4{state == ST_SHIFT}};
            serial_lane_oe  <= 4'hf;
        end
    end

    always_ff @(posedge clk) begin
        pll_running <= ~core_rst;
    end

    // apb: setup edge loads the answer, access phase completes in its first cycle
    wire         setup    = psel & ~penable & ~pready;
    wire         access   = psel & penable & pready;
    wire         hit_ctrl = paddr == `ECLS_OFF_CTRL;
    wire         hit_stat = paddr == `ECLS_OFF_STATUS;
    wire         hit_sent = paddr == `ECLS_OFF_SENT;
    wire         hit_drop = paddr == `ECLS_OFF_DROPS;
    wire         mapped   = hit_ctrl | hit_stat | hit_sent | hit_drop;
    wire         wr       = access & pwrite & ~pslverr;
    wire [31:0]  status   = {26'h0, sync2.rsvd, sync2.bist, sync2.rising,
                             quad_q, state == ST_SHIFT, pll_running}; // reserved pin shown, not obeyed
    wire [31:0]  rd_mux   = hit_ctrl ? {30'h0, ctrl} :
                            hit_stat ? status :
                            hit_sent ? {16'h0, words_sent} :
                            hit_drop ? {16'h0, words_dropped} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // counter writes clear; a count in the same cycle still lands
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl          <= `ECLS_CTRL_RESET;
            words_sent    <= 16'h0000;
            words_dropped <= 16'h0000;
        end else begin
            if (wr && hit_ctrl) begin
                ctrl <= pwdata[1:0];
            end
            if (wr && hit_sent) begin
                words_sent <= {15'h0, load};
            end else if (load) begin
                words_sent <= words_sent + 16'h0001;
            end
            if (wr && hit_drop) begin
                words_dropped <= {15'h0, drop};
            end else if (drop) begin
                words_dropped <= words_dropped + 16'h0001;
            end
        end
    end

    standby_oe_a: assert property (@(posedge clk) sys_rst || !sync2.pdn |=> serial_lane_oe == 4'h0)
        else $error("lanes driven during standby");
    pll_stop_a: assert property (@(posedge clk) core_rst |=> !pll_running)
        else $error("pll running in standby");
    dual_quiet_a: assert property (@(posedge clk) disable iff (core_rst)
        (state == ST_SHIFT) && !quad_q |=> serial_lane_out[3:2] == 2'b00)
        else $error("unused lane toggled in dual mode");
    start_bit_a: assert property (@(posedge clk) disable iff (core_rst)
        load |-> ##2 serial_lane_out[0])
        else $error("frame did not open with start bit");
    dual_len_a: assert property (@(posedge clk) disable iff (core_rst)
        load && !quad_sel |-> ##18 !last_bit ##1 last_bit)
        else $error("dual frame length wrong");
    quad_len_a: assert property (@(posedge clk) disable iff (core_rst)
        load && quad_sel |-> ##11 last_bit)
        else $error("quad frame length wrong");
    edge_take_a: assert property (@(posedge clk) disable iff (core_rst)
        tx_en && can_load && (sync2.rising ? (sync2.strobe && !$past(sync2.strobe)) :
        (!sync2.strobe && $past(sync2.strobe))) |=> state == ST_SHIFT && bit_cnt == 5'h00)
        else $error("selected strobe edge not captured");
    bist_run_a: assert property (@(posedge clk) disable iff (core_rst)
        tx_en && sync2.bist && (state == ST_IDLE) |-> load)
        else $error("self-test left the link idle");
    scr_step_a: assert property (@(posedge clk) disable iff (core_rst)
        load |=> lfsr != $past(lfsr))
        else $error("scrambler did not advance");

    dual_load_c: cover property (@(posedge clk) disable iff (core_rst) load && !quad_sel);
    quad_load_c: cover property (@(posedge clk) disable iff (core_rst) load && quad_sel);
    bist_load_c: cover property (@(posedge clk) disable iff (core_rst) load && sync2.bist);
    drop_c:      cover property (@(posedge clk) disable iff (core_rst) drop);
endmodule

// ==== tb/ecls_far_end.sv ====
// behavioural far-end receiver that rebuilds words from the lanes
`timescale 1ns/100ps
module ecls_far_end (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // lanes and mode
    input  wire logic [3:0]  lane,
    input  wire logic [3:0]  oe,
    input  wire logic        quad,
    // rebuilt word
    output logic      [31:0] word,
    output logic             inv,
    output logic             got,
    output logic             locked
);
    logic [17:0] sr [4];
    logic [15:0] p [4];
    int          n = 0;
    always @(posedge clk) begin
        got <= 1'b0;
        if (rst || !oe[0]) begin
            n = 0;
            locked <= 1'b0;
        end else if (n == 0) begin
            n = lane[0]; // start bit is the only timing reference
        end else begin
            for (int k = 0; k < 4; k++) begin
                sr[k] = {lane[k], sr[k][17:1]};
                p[k] = sr[k][15:0] ^ {16{sr[k][16]}};
            end
            n++;
            if (n == (quad ? 11 : 19)) begin // lanes framed together from the lane 0 start bit, no deskew
                word <= quad ? {p[3][15:8], p[2][15:8], p[1][15:8], p[0][15:8]} : {p[1], p[0]};
                inv <= sr[0][16];
                got <= 1'b1;
                locked <= 1'b1;
                n = 0;
            end
        end
    end
endmodule

// ==== tb/ecls_serializer_tb.sv ====
// self-checking bench for the lane serializer
`timescale 1ns/100ps
`include "ecls_consts.svh"
module ecls_serializer_tb;
    import ecls_pkg::*;
    typedef struct packed {logic [31:0] w; logic q; logic r; logic inv;} ecls_row_s;
    ecls_row_s rows [6] = '{
        '{32'hffffffff, 1'b0, 1'b1, 1'b1}, '{32'hffffffff, 1'b0, 1'b0, 1'b1},
        '{32'h12345678, 1'b0, 1'b1, 1'b0}, '{32'h000001ff, 1'b1, 1'b1, 1'b1},
        '{32'h0000000f, 1'b1, 1'b0, 1'b0}, '{32'ha5a5a51f, 1'b1, 1'b1, 1'b1}};
    logic clk = 0, sys_rst = 1, strb = 0, rise = 1, quad = 0, bist = 0, pdn = 1;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, pll, got, inv, lock;
    logic [7:0] paddr = 8'h00;
    logic [31:0] win = 0, pwdata = 0, prdata, rw, q, w1;
    logic [3:0] lout, loe;
    logic e;
    int err_total = 0, total_checks = 0, cyc = 0, c1;
    ecls_serializer i_dut (.clk(clk), .sys_rst(sys_rst), .parallel_word_in(win),
        .parallel_strobe_clock(strb), .strobe_edge_select(rise), .lane_count_select(quad),
        .self_test_enable(bist), .power_down_n(pdn), .reserved_cfg(1'b0),
        .serial_lane_out(lout), .serial_lane_oe(loe), .pll_running(pll), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ecls_far_end i_far (.clk(clk), .rst(sys_rst), .lane(lout), .oe(loe), .quad(quad),
        .word(rw), .inv(inv), .got(got), .locked(lock));
    always #50 clk = ~clk;
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!quad && loe[0] && lout[3:2] !== 2'b00) begin
            err_total++;
            $display("ERROR upper lanes exp 0 got %h", lout[3:2]);
        end
        if (cyc == 8000) begin
            err_total++;
            give_verdict;
        end
    end
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
        total_checks++;
        if (gt !== ex) begin
            err_total++;
            $display("ERROR %s exp %h got %h", nm, ex, gt);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // the request stands until pready is seen high at a rising edge
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            $display("ERROR apb ready exp 1 got %b", pready);
        end
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wait_got;
        int n;
        n = 0;
        do @(posedge clk); while (got !== 1'b1 && ++n < 100);
        chk("frame seen", 32'h1, {31'h0, got});
    endtask
    // word a settles before the rising edge, its inverse before the falling one
    task send(input logic [31:0] a);
        win <= a;
        @(posedge clk);
        strb <= 1'b1;
        repeat (3) @(posedge clk);
        win <= ~a;
        @(posedge clk);
        strb <= 1'b0;
        wait_got;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b1, `ECLS_OFF_CTRL, 32'h1);
        apb(1'b1, `ECLS_OFF_SENT, 32'h0);
        foreach (rows[i]) begin
            {rise, quad} <= {rows[i].r, rows[i].q};
            repeat (4) @(posedge clk);
            send(rows[i].w ^ {32{~rows[i].r}});
            chk("word", rows[i].w, rw);
            chk("balance flag", {31'h0, rows[i].inv}, {31'h0, inv});
            $display("test row %0d done", i);
        end
        apb(1'b0, `ECLS_OFF_SENT, 32'h0);
        chk("sent", 32'h6, q);
        apb(1'b0, `ECLS_OFF_STATUS, 32'h0);
        chk("status", 32'h09, q & 32'h39);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        // second rising strobe lands mid frame and must be dropped
        {rise, quad} <= 2'b10;
        repeat (4) @(posedge clk);
        repeat (2) begin
            strb <= 1'b1;
            repeat (4) @(posedge clk);
            strb <= 1'b0;
            repeat (4) @(posedge clk);
        end
        wait_got;
        apb(1'b0, `ECLS_OFF_DROPS, 32'h0);
        chk("drops", 32'h1, q);
        $display("test busy drop done");
        {quad, bist} <= 2'b01;
        wait_got;
        {w1, c1} = {rw, cyc};
        wait_got;
        chk("test pattern", w1 + 32'h1, rw);
        chk("frame gap", 32'd19, cyc - c1);
        bist <= 1'b0;
        repeat (40) @(posedge clk);
        pdn <= 1'b0;
        repeat (6) @(posedge clk);
        chk("standby", 32'h0, {loe, pll, lock});
        pdn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("pll", 32'h1, {31'h0, pll});
        $display("test self test and standby done");
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, `ECLS_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h3, q);
        send(32'h0f0f1234);
        chk("scrambled", 32'h0f0f1234 ^ `ECLS_LFSR_SEED, rw);
        $display("test reset and scramble done");
        give_verdict;
    end
endmodule
